// ==== verilog/isc_counter.sv ====
// Instruction execution-state counter
//
// What this block does
// - Total is sum of count times states
// - Fixed six category counts per instruction
// - On-chip cycles 2 states, internal 1
// - Peripheral states depend on bus width
// - External states follow width, mode, waits
// - Per-instruction fetch and byte counts
`timescale 1ns/1ps
`default_nettype none
`include "isc_params.svh"

module isc_counter
  import isc_pkg::*;
#(
  parameter int TOTAL_W = 10,
  // Short-branch class is a separate input since the class code is full
  parameter int BCC_CNT = 2
)
(
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               req_valid,
  input  wire isc_instr_e         req_instr,
  input  wire logic               req_branch,
  input  wire isc_cfg_t           req_cfg,
  output logic                    req_ready_q,
  output logic                    done_q,
  output logic [TOTAL_W-1:0]      states_q
);

  initial
  begin
    if (TOTAL_W < 10)
      $error("TOTAL_W too narrow for worst-case total");
    // Fetch count field is two bits wide
    if (BCC_CNT < 1 || BCC_CNT > 3)
      $error("BCC_CNT outside one to three");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lookup functions

  function automatic isc_cnt_t instr_counts(isc_instr_e ins, logic br);
    isc_cnt_t c;
    c = '0;
    if (br)
    begin
      c[`ISC_CAT_FETCH] = 2'(BCC_CNT);
    end
    else
    begin
      case (ins)
        ISC_ADD_W_IMM, ISC_AND_W_IMM, ISC_AND_L_REG: c[`ISC_CAT_FETCH] = 2'h2;
        ISC_ADD_L_IMM, ISC_AND_L_IMM:                c[`ISC_CAT_FETCH] = 2'h3;
        ISC_BITAND_MEM:
        begin
          c[`ISC_CAT_FETCH] = 2'h2;
          c[`ISC_CAT_BYTE]  = 2'h1;
        end
        default:                                      c[`ISC_CAT_FETCH] = 2'h1;
      endcase
    end
    return c;
  endfunction

  function automatic logic [5:0] cyc_states(isc_cfg_s cfg, logic [2:0] cat);
    logic       is_byte;
    logic [5:0] m;
    logic [5:0] s;
    is_byte = (cat == `ISC_CAT_BYTE);
    m       = {2'h0, cfg.waits};
    s       = `ISC_ST_ONCHIP;
    if (cat == `ISC_CAT_INTERN)
      s = `ISC_ST_INTERN;
    else
    begin
      case (cfg.region)
        ISC_REG_ONCHIP: s = `ISC_ST_ONCHIP;
        ISC_REG_PERIPH: s = cfg.bus16 ? `ISC_ST_P16 : (is_byte ? `ISC_ST_P8_BYTE : `ISC_ST_P8_WIDE);
        ISC_REG_EXTERN:
        begin
          if (cfg.bus16)
            s = cfg.three_state ? 6'(`ISC_ST_X16_3 + m) : `ISC_ST_X16;
          else if (cfg.three_state)
            s = is_byte ? 6'(`ISC_ST_X8_3BYTE + m) : 6'(`ISC_ST_X8_3WIDE + 2 * m);
          else
            s = is_byte ? `ISC_ST_X8_BYTE : `ISC_ST_X8_WIDE;
        end
        default:        s = `ISC_ST_ONCHIP;
      endcase
    end
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Datapath

  isc_state_e          state_q;
  logic [2:0]          cat_q;
  isc_cnt_t            cnt_q;
  isc_cfg_t            cfg_q;
  logic [TOTAL_W-1:0]  acc_q;
  logic [5:0]          cur_states;
  logic [7:0]          term;
  logic                take;

  assign take       = req_valid && req_ready_q;
  // Per-category region config latched from bus controller
  assign cur_states = cyc_states(cfg_q[cat_q], cat_q);
  assign term       = 8'(cnt_q[cat_q] * cur_states);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q     <= ISC_IDLE;
      req_ready_q <= 1'b1;
      cat_q       <= 3'h0;
    end
    else if (state_q == ISC_IDLE)
    begin
      if (take)
      begin
        state_q     <= ISC_ACCUM;
        req_ready_q <= 1'b0;
        cat_q       <= `ISC_CAT_FETCH;
      end
    end
    else if (cat_q == `ISC_CAT_LAST)
    begin
      state_q     <= ISC_IDLE;
      req_ready_q <= 1'b1;
    end
    else
      cat_q <= cat_q + 3'h1;
  end

  // Request is latched so the caller may change inputs after handoff
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= '0;
      cfg_q <= '0;
    end
    else if (take)
    begin
      cnt_q <= instr_counts(req_instr, req_branch);
      cfg_q <= req_cfg;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      acc_q    <= '0;
      states_q <= '0;
      done_q   <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (take)
        acc_q <= '0;
      else if (state_q == ISC_ACCUM)
      begin
        acc_q <= acc_q + TOTAL_W'(term);
        if (cat_q == `ISC_CAT_LAST)
        begin
          states_q <= acc_q + TOTAL_W'(term);
          done_q   <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  logic all_onchip;
  always_comb
  begin
    all_onchip = 1'b1;
    for (int i = 0; i < 6; i++)
      if (req_cfg[i].region != ISC_REG_ONCHIP)
        all_onchip = 1'b0;
  end

  result_latency_a : assert property (@(posedge clk) disable iff (rst)
    take |=> !done_q [*6] ##1 done_q)
    else $error("result pulse not seven cycles after request");

  onchip_total_a : assert property (@(posedge clk) disable iff (rst)
    take && all_onchip && !req_branch && req_instr == ISC_ADD_L_IMM |-> ##7 states_q == 10'(6))
    else $error("on-chip long immediate add total wrong");

  counts_stable_a : assert property (@(posedge clk) disable iff (rst)
    state_q == ISC_ACCUM && cat_q != `ISC_CAT_LAST |=> $stable(cnt_q) && $stable(cfg_q))
    else $error("counts changed during accumulation");

  intern_state_a : assert property (@(posedge clk) disable iff (rst)
    state_q == ISC_ACCUM && cat_q == `ISC_CAT_INTERN |-> cur_states == 6'h1)
    else $error("internal cycle not one state");

  onchip_state_a : assert property (@(posedge clk) disable iff (rst)
    state_q == ISC_ACCUM && cat_q != `ISC_CAT_INTERN && cfg_q[cat_q].region == ISC_REG_ONCHIP
      |-> cur_states == 6'h2)
    else $error("on-chip cycle not two states");

  periph_state_a : assert property (@(posedge clk) disable iff (rst)
    state_q == ISC_ACCUM && cat_q != `ISC_CAT_INTERN && cfg_q[cat_q].region == ISC_REG_PERIPH
      |-> cur_states == (cfg_q[cat_q].bus16 || cat_q == `ISC_CAT_BYTE ? 6'h3 : 6'h6))
    else $error("peripheral cycle states wrong");

  ext_wait_a : assert property (@(posedge clk) disable iff (rst)
    state_q == ISC_ACCUM && cat_q == `ISC_CAT_FETCH && cfg_q[0].region == ISC_REG_EXTERN
      && cfg_q[0].three_state && !cfg_q[0].bus16 |-> cur_states == 6'(6 + 2 * cfg_q[0].waits))
    else $error("external three-state word states wrong");

  bitand_cnt_a : assert property (@(posedge clk) disable iff (rst)
    take && !req_branch && req_instr == ISC_BITAND_MEM |=> cnt_q[0] == 2'h2 && cnt_q[3] == 2'h1)
    else $error("memory bit-and counts wrong");

  branch_cnt_a : assert property (@(posedge clk) disable iff (rst)
    take && req_branch |=> cnt_q[0] == 2'h2 && cnt_q[5] == 2'h0)
    else $error("short branch counts wrong");

  cov_branch_c : cover property (@(posedge clk) disable iff (rst) take && req_branch ##7 done_q);
  cov_extern_c : cover property (@(posedge clk) disable iff (rst)
    state_q == ISC_ACCUM && cfg_q[cat_q].region == ISC_REG_EXTERN && cnt_q[cat_q] != 2'h0);
  cov_b2b_c    : cover property (@(posedge clk) disable iff (rst) done_q && take);

endmodule

`default_nettype wire

// ==== shared/isc_params.svh ====
// Cycle categories and state costs for the instruction state counter
`ifndef ISC_PARAMS_SVH
`define ISC_PARAMS_SVH

// Category positions in the count vector
`define ISC_CAT_FETCH   3'd0
`define ISC_CAT_BRADDR  3'd1
`define ISC_CAT_STACK   3'd2
`define ISC_CAT_BYTE    3'd3
`define ISC_CAT_WORD    3'd4
`define ISC_CAT_INTERN  3'd5
`define ISC_CAT_LAST    3'd5

// States per cycle
`define ISC_ST_ONCHIP   6'd2
`define ISC_ST_INTERN   6'd1
`define ISC_ST_P8_WIDE  6'd6
`define ISC_ST_P8_BYTE  6'd3
`define ISC_ST_P16      6'd3
`define ISC_ST_X8_WIDE  6'd4
`define ISC_ST_X8_BYTE  6'd2
`define ISC_ST_X16      6'd2
`define ISC_ST_X8_3WIDE 6'd6
`define ISC_ST_X8_3BYTE 6'd3
`define ISC_ST_X16_3    6'd3

// Cycles from request taken to result pulse
`define ISC_LATENCY     7

`endif

// ==== shared/isc_pkg.sv ====
// Types for the instruction state counter
package isc_pkg;

  typedef enum logic [1:0]
  {
    ISC_REG_ONCHIP = 2'h0,
    ISC_REG_PERIPH = 2'h1,
    ISC_REG_EXTERN = 2'h2
  } isc_region_e;

  typedef struct packed
  {
    isc_region_e region;
    logic        bus16;
    logic        three_state;
    logic [3:0]  waits;
  } isc_cfg_s;

  typedef isc_cfg_s [5:0] isc_cfg_t;

  typedef logic [5:0][1:0] isc_cnt_t;

  typedef enum logic [3:0]
  {
    ISC_ADD_B_IMM   = 4'h0,
    ISC_ADD_B_REG   = 4'h1,
    ISC_ADD_W_IMM   = 4'h2,
    ISC_ADD_W_REG   = 4'h3,
    ISC_ADD_L_IMM   = 4'h4,
    ISC_ADD_L_REG   = 4'h5,
    ISC_ADDS        = 4'h6,
    ISC_ADDX        = 4'h7,
    ISC_AND_B       = 4'h8,
    ISC_AND_W_IMM   = 4'h9,
    ISC_AND_W_REG   = 4'ha,
    ISC_AND_L_IMM   = 4'hb,
    ISC_AND_L_REG   = 4'hc,
    ISC_AND_WITH_CONDITION_BITS = 4'hd,
    ISC_BITAND_REG  = 4'he,
    ISC_BITAND_MEM  = 4'hf
  } isc_instr_e;

  typedef enum logic
  {
    ISC_IDLE  = 1'b0,
    ISC_ACCUM = 1'b1
  } isc_state_e;

endpackage

// ==== test/isc_bus_model.sv ====
// Bus controller model supplying region configuration per cycle category
`timescale 1ns/1ps
`default_nettype none

module isc_bus_model
  import isc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       roll,
  input  wire logic [1:0] mode,
  output var  isc_cfg_t   cfg
);
  integer      seed = 32'h506a;
  logic [31:0] r;
  isc_cfg_s    c;

  ////////////////////////////////////////////////////////////////////////////
  // supplies width, mode, waits
  // Only changes between instructions; a mid-count change has no meaning
  always @(posedge clk)
    if (roll)
      for (int i = 0; i < 6; i++)
      begin
        r = $random(seed);
        c = isc_cfg_s'(r[7:0]);
        // Region code 3 is unused; fold it onto external
        if (r[7:6] == 2'h3)
          c.region = ISC_REG_EXTERN;
        if (mode == 2'h1)
          c.region = ISC_REG_ONCHIP;
        if (mode == 2'h2)
          c = '{ISC_REG_EXTERN, 1'b0, 1'b1, 4'hf};
        if (mode == 2'h3)
          c = '{ISC_REG_PERIPH, 1'b0, r[9], r[13:10]};
        cfg[i] <= c;
      end
endmodule

`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench for the instruction state counter
`timescale 1ns/1ps
`default_nettype none

module tb
  import isc_pkg::*;
;
  logic       clk;
  logic       rst;
  logic       req_valid;
  isc_instr_e req_instr;
  logic       req_branch;
  isc_cfg_t   req_cfg;
  logic       req_ready_q;
  logic       done_q;
  logic [9:0] states_q;
  logic       roll;
  logic [1:0] mode;
  integer     seed;
  int         fail_count;
  int         comparisons;

  isc_counter u_isc_counter (.clk(clk), .rst(rst), .req_valid(req_valid), .req_instr(req_instr),
    .req_branch(req_branch), .req_cfg(req_cfg), .req_ready_q(req_ready_q), .done_q(done_q),
    .states_q(states_q));
  isc_bus_model u_isc_bus_model (.clk(clk), .roll(roll), .mode(mode), .cfg(req_cfg));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic int spc(isc_cfg_s c, logic b);
    case (c.region)
      ISC_REG_ONCHIP: return 2;
      ISC_REG_PERIPH: return c.bus16 ? 3 : (b ? 3 : 6);
      default: return c.bus16 ? (c.three_state ? 3 + c.waits : 2)
                              : (c.three_state ? (b ? 3 + c.waits : 6 + 2 * c.waits) : (b ? 2 : 4));
    endcase
  endfunction

  function automatic int fetches(isc_instr_e i, logic b);
    if (b)
      return 2;
    case (i)
      ISC_ADD_W_IMM, ISC_AND_W_IMM, ISC_AND_L_REG, ISC_BITAND_MEM: return 2;
      ISC_ADD_L_IMM, ISC_AND_L_IMM: return 3;
      default: return 1;
    endcase
  endfunction

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    comparisons++;
    if (!ok)
    begin
      fail_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  // Called on a falling edge; leaves valid high so a following call runs back to back
  task automatic op(input isc_instr_e ins, input logic br);
    logic [9:0] exp;
    int         n;
    n = 0;
    while (req_ready_q !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    if (req_ready_q !== 1'b1)
    begin
      check(1'b0, "ready timeout");
      end_of_test;
    end
    req_valid = 1'b1;
    req_instr = ins;
    req_branch = br;
    exp = 10'(fetches(ins, br) * spc(req_cfg[0], 1'b0)
            + ((ins == ISC_BITAND_MEM && !br) ? spc(req_cfg[3], 1'b1) : 0));
    @(negedge clk);
    // Busy requests must be ignored, so disturb them
    req_instr = isc_instr_e'(4'($random(seed)));
    req_branch = ~br;
    for (int k = 0; k < 6; k++)
    begin
      check(done_q === 1'b0 && req_ready_q === 1'b0, "busy flags");
      @(negedge clk);
    end
    check(done_q === 1'b1 && req_ready_q === 1'b1, "done flags");
    check(states_q === exp, "state total");
  endtask

  task automatic idle(input logic [1:0] m);
    req_valid = 1'b0;
    roll = 1'b1;
    mode = m;
    @(negedge clk);
    roll = 1'b0;
    @(negedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 32'h506a;
    fail_count = 0;
    comparisons = 0;
    rst = 1'b1;
    req_valid = 1'b0;
    req_instr = ISC_ADD_B_IMM;
    req_branch = 1'b0;
    roll = 1'b0;
    mode = 2'h0;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    check(req_ready_q === 1'b1 && done_q === 1'b0 && states_q === 10'h000, "reset values");
    // Fixed corners: on-chip, slowest external, 8-bit peripheral
    for (int m = 1; m < 4; m++)
    begin
      idle(2'(m));
      for (int i = 0; i < 17; i++)
        op(isc_instr_e'(4'(i)), i == 16);
      $display("test mode %0d done", m);
    end
    for (int t = 0; t < 60; t++)
    begin
      idle(2'h0);
      repeat (3) op(isc_instr_e'(4'($random(seed))), 3'($random(seed)) == 3'h0);
    end
    $display("test random done");
    end_of_test;
  end
endmodule

`default_nettype wire
